// ==== pcd_clk_div.v ====
// binary clock-enable divider that switches ratio only at a period boundary
`timescale 1ns/10ps
`include "pcd_regs.vh"
module pcd_clk_div #(
    parameter CNT_W = 7
) (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire ce_i,
    input wire [2:0] div_i,
    output reg tick_o,
    output reg [2:0] div_act_o
);
    reg [CNT_W-1:0] cnt_r;
    wire [CNT_W-1:0] term;

    assign term = ({{(CNT_W-1){1'b0}}, 1'b1} << div_act_o) - {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= {CNT_W{1'b0}};
            div_act_o <= `PCD_CD_RESET;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (ce_i) begin
                if (cnt_r >= term) begin
                    // a new ratio is taken only here, so no period is ever cut short
                    cnt_r <= {CNT_W{1'b0}};
                    div_act_o <= div_i;
                    tick_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ==== pcd_clock_ctrl.v ====
// PLL clock generation, core clock divider and clock control register
//
// What this block does
// - PLL clock is 512 times the 32.768 kHz crystal, nominally 16.78 MHz.
// - core runs at PLL clock or a binary submultiple chosen by divider field.
// - after reset the core clock is PLL clock divided by 8, 2.097152 MHz.
// - converter clocks come from PLL clock; modulator rate equals crystal rate in PLL variant, crystal/512 in direct variant.
// - direct-crystal variant: core clock is crystal divided by two to divider.
// - one special-function register holds PLL and divider configuration.
// - divider codes 000 to 011 give 16.78, 8.39, 4.19 and 2.10 MHz.
// - PLL variant only: with fast bit set, interrupts run at fastest clock, then divider clock resumes.
`timescale 1ns/10ps
`include "pcd_regs.vh"
module pcd_clock_ctrl #(
    parameter DIRECT_XTAL = 0,
    parameter [27:0] NCO_INC = 28'd16777216,
    parameter [27:0] NCO_MOD = 28'd250000000
) (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    input wire xtal_i,
    input wire irq_active_i,
    output reg [7:0] sfr_rdata_o,
    output reg sfr_hit_o,
    output reg pll_clk_en_o,
    output reg core_clk_en_o,
    output reg mod_clk_en_o,
    output reg osc_pd_o,
    output reg pll_lock_o
);
    localparam ST_SEL = 2'b01;
    localparam ST_FAST = 2'b10;
    localparam [9:0] PLL_MULT = `PCD_PLL_MULT;
    localparam [9:0] LOCK_TOL = `PCD_LOCK_TOL;
    localparam [7:0] CTRL_RST = `PCD_CTRL_RESET;
    localparam [7:0] RSVD_MASK = `PCD_RSVD_MASK;

    reg osc_pd_r;
    reg fast_r;
    reg [2:0] cd_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] div_sel;
    reg [27:0] nco_r;
    reg nco_tick_r;
    reg xs1_r;
    reg xs2_r;
    reg xs3_r;
    reg xstable_r;
    reg xrise_r;
    reg [10:0] per_cnt_r;
    reg lock_r;
    reg [8:0] mod_cnt_r;
    wire [28:0] nco_sum;
    wire base_tick;
    wire wr_hit;
    wire div_tick;
    wire [7:0] ctrl_view;

    // exact rational NCO: 16777216 / 250000000 of the system clock
    assign nco_sum = {1'b0, nco_r} + {1'b0, NCO_INC};

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nco_r <= 28'h0000000;
            nco_tick_r <= 1'b0;
        end else if (nco_sum >= {1'b0, NCO_MOD}) begin
            nco_r <= nco_sum[27:0] - NCO_MOD;
            nco_tick_r <= 1'b1;
        end else begin
            nco_r <= nco_sum[27:0];
            nco_tick_r <= 1'b0;
        end
    end

    // crystal pin synchroniser; a level counts once stages two and three agree
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xs1_r <= 1'b0;
            xs2_r <= 1'b0;
            xs3_r <= 1'b0;
            xstable_r <= 1'b0;
            xrise_r <= 1'b0;
        end else begin
            xs1_r <= xtal_i;
            xs2_r <= xs1_r;
            xs3_r <= xs2_r;
            xrise_r <= 1'b0;
            if (xs2_r == xs3_r) begin
                xstable_r <= xs3_r;
                xrise_r <= xs3_r & ~xstable_r;
            end
        end
    end

    // direct variant counts crystal edges, PLL variant counts the multiplied clock
    assign base_tick = (DIRECT_XTAL != 0) ? xrise_r : nco_tick_r;

    // lock monitor: PLL ticks per crystal period must be 512 within tolerance
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            per_cnt_r <= 11'h000;
            lock_r <= 1'b1;
        end else if (DIRECT_XTAL != 0) begin
            per_cnt_r <= 11'h000;
            lock_r <= 1'b0;
        end else if (xrise_r) begin
            per_cnt_r <= {10'h000, nco_tick_r};
            lock_r <= (per_cnt_r >= {1'b0, PLL_MULT - LOCK_TOL}) &&
                      (per_cnt_r <= {1'b0, PLL_MULT + LOCK_TOL});
        end else if (nco_tick_r) begin
            if (per_cnt_r == {PLL_MULT, 1'b0}) begin
                // crystal gone: loop rails, report unlocked and hold count
                lock_r <= 1'b0;
            end else begin
                per_cnt_r <= per_cnt_r + 11'h001;
            end
        end
    end

    // modulator strobe every 512 PLL ticks, phase-tied to the core divider source
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mod_cnt_r <= 9'h000;
            mod_clk_en_o <= 1'b0;
        end else begin
            mod_clk_en_o <= 1'b0;
            if (base_tick) begin
                mod_cnt_r <= mod_cnt_r + 9'h001;
                if (mod_cnt_r == 9'h1ff) begin
                    mod_clk_en_o <= 1'b1;
                end
            end
        end
    end

    // control register
    assign wr_hit = sfr_wr_i && (sfr_addr_i == `PCD_CTRL_ADDR);

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_pd_r <= CTRL_RST[`PCD_BIT_OSC_PD];
            fast_r <= CTRL_RST[`PCD_BIT_FAST];
            cd_r <= `PCD_CD_RESET;
        end else if (wr_hit) begin
            osc_pd_r <= sfr_wdata_i[`PCD_BIT_OSC_PD];
            fast_r <= sfr_wdata_i[`PCD_BIT_FAST];
            cd_r <= sfr_wdata_i[`PCD_CD_MSB:`PCD_CD_LSB];
        end
    end

    // reserved bits keep their reset pattern; the direct variant shows only the divider
    assign ctrl_view = (DIRECT_XTAL != 0) ? {5'h00, cd_r} :
                       ({osc_pd_r, lock_r, 6'h00} | (CTRL_RST & RSVD_MASK) | {4'h0, fast_r, cd_r});

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_hit_o <= 1'b0;
        end else begin
            sfr_hit_o <= sfr_rd_i && (sfr_addr_i == `PCD_CTRL_ADDR);
            sfr_rdata_o <= (sfr_rd_i && (sfr_addr_i == `PCD_CTRL_ADDR)) ? ctrl_view : 8'h00;
        end
    end

    // interrupt speed-up: fastest ratio while an interrupt is serviced
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_SEL: begin
                if (fast_r && irq_active_i && (DIRECT_XTAL == 0)) begin
                    state_nxt = ST_FAST;
                end
            end
            ST_FAST: begin
                if (!irq_active_i) begin
                    state_nxt = ST_SEL;
                end
            end
            default: begin
                state_nxt = ST_SEL;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_SEL;
        end else begin
            state_r <= state_nxt;
        end
    end

    always @* begin
        if (state_r == ST_FAST) begin
            div_sel = `PCD_CD_FASTEST;
        end else begin
            div_sel = cd_r;
        end
    end

    pcd_clk_div #(
        .CNT_W(`PCD_DIV_CNT_W)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(base_tick),
        .div_i(div_sel),
        .tick_o(div_tick),
        .div_act_o()
    );

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pll_clk_en_o <= 1'b0;
            core_clk_en_o <= 1'b0;
            osc_pd_o <= 1'b0;
            pll_lock_o <= 1'b0;
        end else begin
            pll_clk_en_o <= base_tick;
            core_clk_en_o <= div_tick;
            osc_pd_o <= osc_pd_r;
            pll_lock_o <= lock_r;
        end
    end
endmodule

// ==== pcd_clock_ctrl_assertions.sv ====
// port assertions for the clock control block
`timescale 1ns/10ps
module pcd_clock_ctrl_chk #(
    parameter DIRECT_XTAL = 0
) (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    input wire irq_active_i,
    input wire [7:0] sfr_rdata_o,
    input wire sfr_hit_o,
    input wire pll_clk_en_o,
    input wire core_clk_en_o,
    input wire mod_clk_en_o,
    input wire osc_pd_o
);
    reg [7:0] per_r;
    reg [9:0] modc_r;
    reg [1:0] seen_r;
    reg [3:0] cfg_r;
    reg [1:0] fastn_r;
    wire [7:0] per_w = per_r + {7'h00, pll_clk_en_o};
    wire [9:0] mod_w = modc_r + {9'h000, pll_clk_en_o};
    // direct variant shows only the divider field
    wire [5:0] view_w = (DIRECT_XTAL != 0) ? {3'b000, cfg_r[2:0]} : {2'b01, cfg_r};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_cfg_wr;
        sfr_wr_i && sfr_addr_i == 8'hd7;
    endsequence
    sequence s_cfg_rd;
        sfr_rd_i && sfr_addr_i == 8'hd7;
    endsequence
    // periods count only after a first pulse: divider phase at reset is free
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            per_r <= 8'h00;
            modc_r <= 10'h000;
            seen_r <= 2'b00;
            cfg_r <= 4'h3;
            fastn_r <= 2'b00;
        end else begin
            per_r <= core_clk_en_o ? 8'h00 : per_w;
            modc_r <= mod_clk_en_o ? 10'h000 : mod_w;
            seen_r <= seen_r | {mod_clk_en_o, core_clk_en_o};
            if (sfr_wr_i && sfr_addr_i == 8'hd7) begin
                cfg_r <= sfr_wdata_i[3:0];
            end
            if (!(cfg_r[3] && irq_active_i && DIRECT_XTAL == 0)) begin
                fastn_r <= 2'b00;
            end else if (core_clk_en_o && fastn_r != 2'b11) begin
                fastn_r <= fastn_r + 2'b01;
            end
        end
    end
    chk_read_hit: assert property (s_cfg_rd |=> sfr_hit_o)
        else $error("no hit");
    chk_read_view: assert property (s_cfg_rd |=> sfr_rdata_o[5:0] == $past(view_w))
        else $error("bad view");
    chk_hit_drops: assert property (s_cfg_rd ##1 !sfr_rd_i |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("stale read");
    chk_unmapped_read: assert property (sfr_rd_i && sfr_addr_i != 8'hd7 |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("unmapped read");
    chk_osc_pd_copy: assert property (s_cfg_wr ##1 (!sfr_wr_i) [*2] |-> osc_pd_o == $past(sfr_wdata_i[7], 2))
        else $error("osc pd");
    chk_core_pow2: assert property (core_clk_en_o && seen_r[0] |-> per_w != 0 && (per_w & (per_w - 8'h01)) == 0)
        else $error("core period");
    chk_fast_ratio: assert property (core_clk_en_o && fastn_r == 2'b11 |-> per_w == 8'h01)
        else $error("fast ratio");
    chk_mod_period: assert property (mod_clk_en_o && seen_r[1] |-> mod_w == 10'd512)
        else $error("mod period");
endmodule
bind pcd_clock_ctrl pcd_clock_ctrl_chk #(.DIRECT_XTAL(DIRECT_XTAL)) u_chk (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .irq_active_i(irq_active_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .pll_clk_en_o(pll_clk_en_o),
    .core_clk_en_o(core_clk_en_o), .mod_clk_en_o(mod_clk_en_o), .osc_pd_o(osc_pd_o));

// ==== pcd_regs.vh ====
// register map, field positions, reset values and timing constants of the clock block
`ifndef PCD_REGS_VH
`define PCD_REGS_VH
`define PCD_CTRL_ADDR 8'hd7
`define PCD_CTRL_RESET 8'h53
`define PCD_BIT_OSC_PD 7
`define PCD_BIT_LOCK 6
`define PCD_BIT_FAST 3
`define PCD_CD_MSB 2
`define PCD_CD_LSB 0
`define PCD_CD_RESET 3'h3
`define PCD_CD_FASTEST 3'h0
`define PCD_RSVD_MASK 8'h30
`define PCD_XTAL_HZ 32768
`define PCD_PLL_MULT 512
`define PCD_PLL_HZ (`PCD_XTAL_HZ * `PCD_PLL_MULT)
`define PCD_SYS_HZ 250000000
`define PCD_LOCK_TOL 2
`define PCD_DIV_CNT_W 7
`endif

// ==== pcd_xtal_model.sv ====
// free-running watch crystal at the crystal pin
`timescale 1ns/10ps
module pcd_xtal_model #(
    parameter HALF_NS = 2048
) (
    output reg xtal_o
);
    initial xtal_o = 1'b0;
    always #(HALF_NS) xtal_o = ~xtal_o;
endmodule

// ==== tb_pll_core_clock_divider.sv ====
// self-checking bench for the clock control block
`timescale 1ns/10ps
module tb_pll_core_clock_divider;
    reg sys_clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg irq = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wd = 8'h00;
    wire xtal, hit, pll, core, mod, opd, lock;
    wire [7:0] rdata;
    wire xhit, xpll, xcore;
    wire [7:0] xrdata;
    reg wrx = 1'b0;
    reg [15:0] vx;
    integer miscompares = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer n;
    reg [15:0] v;
    always #2 sys_clk_i = ~sys_clk_i;
    pcd_xtal_model #(.HALF_NS(2048)) u_xtal (.xtal_o(xtal));
    // a PLL tick every second cycle keeps long periods short
    pcd_clock_ctrl #(.NCO_INC(28'd1), .NCO_MOD(28'd2)) u_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rd_i(rd), .xtal_i(xtal), .irq_active_i(irq),
        .sfr_rdata_o(rdata), .sfr_hit_o(hit), .pll_clk_en_o(pll), .core_clk_en_o(core), .mod_clk_en_o(mod),
        .osc_pd_o(opd), .pll_lock_o(lock));
    // direct-crystal variant on its own write strobe, sharing the rest of the bus
    pcd_clock_ctrl #(.DIRECT_XTAL(1)) u_dut_x (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .sfr_addr_i(addr), .sfr_wr_i(wrx), .sfr_wdata_i(wd), .sfr_rd_i(rd), .xtal_i(xtal), .irq_active_i(irq),
        .sfr_rdata_o(xrdata), .sfr_hit_o(xhit), .pll_clk_en_o(xpll), .core_clk_en_o(xcore), .mod_clk_en_o(),
        .osc_pd_o(), .pll_lock_o());
    task final_report;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_i);
            addr <= a;
            wd <= d;
            wr <= 1'b1;
            @(posedge sys_clk_i);
            wr <= 1'b0;
        end
    endtask
    task wrx_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_i);
            addr <= a;
            wd <= d & 8'h07;
            wrx <= 1'b1;
            @(posedge sys_clk_i);
            wrx <= 1'b0;
        end
    endtask
    // crystal rises per core period of the direct variant, third period
    task per_x;
        integer i;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                v = 16'h0000;
                do begin
                    @(posedge sys_clk_i);
                    #1 v = v + xpll;
                end while (!xcore && v < 16'd600);
            end
        end
    endtask
    // result is {hit, data} seen in the answer cycle
    task rd_reg(input [7:0] a);
        begin
            @(posedge sys_clk_i);
            addr <= a;
            rd <= 1'b1;
            @(posedge sys_clk_i);
            rd <= 1'b0;
            #1 v = {7'h00, hit, rdata};
            vx = {7'h00, xhit, xrdata};
        end
    endtask
    // PLL ticks per period; third period, after any deferred change
    task per(input sel);
        integer i;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                v = 16'h0000;
                do begin
                    @(posedge sys_clk_i);
                    #1 v = v + pll;
                end while (!(sel ? mod : core) && v < 16'd600);
            end
        end
    endtask
    task reset_check;
        begin
            @(posedge sys_clk_i);
            arst_n_i <= 1'b0;
            repeat (16) @(posedge sys_clk_i);
            arst_n_i <= 1'b1;
            rd_reg(8'hd7);
            chk(v, 16'h0153);
            chk(vx, 16'h0103);
            per(1'b0);
            chk(v, 16'h0008);
        end
    endtask
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            final_report;
        end
    end
    initial begin
        reset_check;
        wrx_reg(8'hd7, 8'h01);
        rd_reg(8'hd7);
        chk(vx, 16'h0101);
        // bench stands for a 5 V part, so divider zero is a legal setting
        for (n = 0; n < 8; n = n + 1) begin
            wr_reg(8'hd7, n[7:0]);
            per(1'b0);
            chk(v, 16'h0001 << n);
        end
        wr_reg(8'hd7, 8'hff);
        wr_reg(8'hd6, 8'h00);
        rd_reg(8'hd6);
        chk(v, 16'h0000);
        rd_reg(8'hd7);
        chk(v & 16'h01bf, 16'h019f);
        chk({15'h0000, opd}, 16'h0001);
        @(posedge sys_clk_i);
        irq <= 1'b1;
        per(1'b0);
        chk(v, 16'h0001);
        @(posedge sys_clk_i);
        irq <= 1'b0;
        per(1'b0);
        chk(v, 16'h0080);
        per(1'b1);
        chk(v, 16'd512);
        chk({15'h0000, lock}, 16'h0001);
        per_x;
        chk(v, 16'h0002);
        reset_check;
        final_report;
    end
endmodule
